/* File: common/crs_defines.vh */
/*
 * constants of the core regulator start-up sequencer: clock rate, start-up
 * timing, boot level and voltage code decode.
 * assumes the sequencer clock runs at the rate given here.
 */
`ifndef CRS_DEFINES_VH
`define CRS_DEFINES_VH

// ----------------------------------------------------------------------------
// clock
// ----------------------------------------------------------------------------
`define CRS_CLK_MHZ 125

// ----------------------------------------------------------------------------
// start-up timing
// ----------------------------------------------------------------------------
`define CRS_T_START_US 100
`define CRS_START_CYC (`CRS_T_START_US * `CRS_CLK_MHZ)
`define CRS_T_POWER_GOOD_OUT_US 6800
`define CRS_POWER_GOOD_OUT_CYC (`CRS_T_POWER_GOOD_OUT_US * `CRS_CLK_MHZ)
`define CRS_T_POWER_GOOD_OUT_SEQ_US 7000
`define CRS_CLKEN_CYC 13
`define CRS_CNT_W 20

// ----------------------------------------------------------------------------
// voltage levels, in units of 0.1 mV
// ----------------------------------------------------------------------------
`define CRS_MV_W 14
`define CRS_BOOT_LEVEL 14'd12000
`define CRS_CODE_ZERO_LEVEL 14'd15000
`define CRS_CODE_STEP 14'd125
`define CRS_CODE_LAST 7'h6f
`define CRS_NEAR_WINDOW_MV 20

// ----------------------------------------------------------------------------
// soft-start slew currents in microamperes, fast slew rate in mV per us
// ----------------------------------------------------------------------------
`define CRS_SLEW_SLOW_UA 41
`define CRS_SLEW_FAST_UA 200
`define CRS_SLEW_FAST_MV_PER_US 10

`endif

/* File: rtl/crs_code_decoder.v */
/*
 * decoder from the 7-bit voltage code to a target level in 0.1 mV units.
 * assumes a code already synchronised to the caller's clock.
 */
`include "crs_defines.vh"

module crs_code_decoder (
    input wire [6:0] voltage_code,
    output wire [`CRS_MV_W-1:0] target_level
);

    // ------------------------------------------------------------------------
    // decode
    // ------------------------------------------------------------------------
    wire [`CRS_MV_W-1:0] code_wide; // code widened to the level width
    wire [`CRS_MV_W-1:0] drop; // total drop below the zero-code level

    assign code_wide = {{(`CRS_MV_W-7){1'b0}}, voltage_code}; // RULE10
    assign drop = code_wide * `CRS_CODE_STEP;
    // codes past the table bottom give zero volts
    assign target_level = (voltage_code > `CRS_CODE_LAST) ? {`CRS_MV_W{1'b0}} :
        (`CRS_CODE_ZERO_LEVEL - drop); // RULE9

endmodule // crs_code_decoder

/* File: rtl/crs_sequencer.v */
/*
 * start-up sequencer of a single-phase core regulator: boot ramp, clock
 * enable, slew to the coded target, power good and conduction mode select.
 * assumes all control inputs are asynchronous pins and that the analog loop
 * reports through output_voltage_sense when the output is near the reference.
 */
// What this block does
// (RULE1) start only with supply good and enable high
// (RULE2) after about 100 us ramp to 1.2 V boot
// (RULE3) force continuous conduction during start-up, ignore mode inputs
// (RULE4) boot ramp uses the slow 41 uA slew
// (RULE5) near boot, count 13 clocks, drive clock enable low
// (RULE6) then fast 200 uA slew to the coded target
// (RULE7) power good about 7 ms into start-up
// (RULE8) after start-up target follows the voltage code
// (RULE9) code zero is 1.5000 V, step 12.5 mV down
// (RULE10) code bit 0 is least significant bit
// (RULE11) clock enable low to power good: 6.8 ms
// (RULE12) enable or supply loss returns to idle
`include "crs_defines.vh"

module crs_sequencer #(
    parameter [`CRS_CNT_W-1:0] START_CYC = `CRS_START_CYC,
    parameter [`CRS_CNT_W-1:0] POWER_GOOD_OUT_CYC = `CRS_POWER_GOOD_OUT_CYC
) (
    input wire sys_clk,
    input wire rstn,
    input wire supply_ok_in,
    input wire regulator_enable_in,
    input wire [6:0] voltage_code,
    input wire output_voltage_sense,
    input wire sleep_wake_n,
    input wire forced_diode_emulation_in,
    output wire [`CRS_MV_W-1:0] reference_level,
    output wire soft_ramp_en,
    output wire slew_fast,
    output wire continuous_conduction,
    output wire diode_emulation,
    output wire enhanced_diode_emulation,
    output wire clock_enable_n,
    output wire power_good_out,
    output wire power_good_oe
);

    // ------------------------------------------------------------------------
    // states
    // ------------------------------------------------------------------------
    localparam [2:0] ST_IDLE = 3'h0; // waiting for supply and enable
    localparam [2:0] ST_DELAY = 3'h1; // pause before the boot ramp
    localparam [2:0] ST_RAMP = 3'h2; // slow ramp to boot level
    localparam [2:0] ST_COUNT = 3'h3; // near boot, counting clocks
    localparam [2:0] ST_SLEW = 3'h4; // fast slew, power good pending
    localparam [2:0] ST_RUN = 3'h5; // regulating, power good high

    // ------------------------------------------------------------------------
    // input synchronisers
    // ------------------------------------------------------------------------
    localparam SYNC_W = 12;
    wire [SYNC_W-1:0] pins_async; // raw pin levels
    reg [SYNC_W-1:0] sync1_q; // first stage, read only by sync2_q
    reg [SYNC_W-1:0] sync2_q; // safe levels

    assign pins_async = {forced_diode_emulation_in, sleep_wake_n, output_voltage_sense,
        voltage_code, regulator_enable_in, supply_ok_in};

    // two flops on every pin
    always @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            sync1_q <= {SYNC_W{1'b0}};
            sync2_q <= {SYNC_W{1'b0}};
        end else begin
            sync1_q <= pins_async;
            sync2_q <= sync1_q;
        end
    end

    wire supply_ok = sync2_q[0]; // supply above power-on threshold
    wire enable_on = sync2_q[1]; // regulator enable seen high
    wire [6:0] code_s = sync2_q[8:2]; // synchronised voltage code
    wire near_ref = sync2_q[9]; // output within window of reference
    wire wake_n = sync2_q[10]; // low in deeper sleep
    wire fde = sync2_q[11]; // forced diode emulation request
    wire run_ok = supply_ok & enable_on; // RULE1

    // ------------------------------------------------------------------------
    // code decode
    // ------------------------------------------------------------------------
    wire [`CRS_MV_W-1:0] code_level; // decoded target level

    crs_code_decoder u_decoder (
        .voltage_code(code_s),
        .target_level(code_level)
    );

    // ------------------------------------------------------------------------
    // sequencer state and counter
    // ------------------------------------------------------------------------
    reg [2:0] state_q; // current state
    reg [2:0] state_d; // next state
    reg [`CRS_CNT_W-1:0] cnt_q; // cycles spent in the current state
    reg [`CRS_CNT_W-1:0] cnt_d; // next count

    // next state
    always @* begin
        state_d = state_q;
        cnt_d = cnt_q + 1'b1;
        if (!run_ok) begin
            state_d = ST_IDLE; // RULE12
            cnt_d = {`CRS_CNT_W{1'b0}};
        end else begin
            case (state_q)
                ST_IDLE: begin
                    state_d = ST_DELAY; // RULE1
                    cnt_d = {`CRS_CNT_W{1'b0}};
                end
                ST_DELAY: begin
                    if (cnt_q == START_CYC - 1'b1) begin
                        state_d = ST_RAMP; // RULE2
                        cnt_d = {`CRS_CNT_W{1'b0}};
                    end
                end
                ST_RAMP: begin
                    if (near_ref) begin
                        state_d = ST_COUNT; // RULE5
                        cnt_d = {`CRS_CNT_W{1'b0}};
                    end
                end
                ST_COUNT: begin
                    if (cnt_q == `CRS_CLKEN_CYC - 1) begin
                        state_d = ST_SLEW; // RULE5
                        cnt_d = {`CRS_CNT_W{1'b0}};
                    end
                end
                ST_SLEW: begin
                    if (cnt_q == POWER_GOOD_OUT_CYC - 1'b1) begin
                        state_d = ST_RUN; // RULE11 RULE7
                        cnt_d = {`CRS_CNT_W{1'b0}};
                    end
                end
                ST_RUN: begin
                    cnt_d = cnt_q; // count idles once running
                end
                default: begin
                    state_d = ST_IDLE;
                    cnt_d = {`CRS_CNT_W{1'b0}};
                end
            endcase
        end
    end

    // state registers
    always @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            state_q <= ST_IDLE;
            cnt_q <= {`CRS_CNT_W{1'b0}};
        end else begin
            state_q <= state_d;
            cnt_q <= cnt_d;
        end
    end

    // ------------------------------------------------------------------------
    // registered outputs
    // ------------------------------------------------------------------------
    reg [`CRS_MV_W-1:0] ref_q; // reference level to the soft-start stage
    reg ramp_q; // soft-start current on
    reg fast_q; // fast slew selected
    reg ccm_q; // continuous conduction
    reg dem_q; // diode emulation
    reg edem_q; // enhanced diode emulation
    reg clk_en_n_q; // clock enable, active low
    reg power_good_out_q; // power good

    // outputs follow the next state so they line up with it
    always @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            ref_q <= {`CRS_MV_W{1'b0}};
            ramp_q <= 1'b0;
            fast_q <= 1'b0;
            ccm_q <= 1'b1;
            dem_q <= 1'b0;
            edem_q <= 1'b0;
            clk_en_n_q <= 1'b1;
            power_good_out_q <= 1'b0;
        end else begin
            case (state_d)
                ST_RAMP, ST_COUNT: begin
                    ref_q <= `CRS_BOOT_LEVEL; // RULE2
                    ramp_q <= 1'b1;
                    fast_q <= 1'b0; // RULE4
                end
                ST_SLEW, ST_RUN: begin
                    ref_q <= code_level; // RULE6 RULE8
                    ramp_q <= 1'b1;
                    fast_q <= 1'b1; // RULE6
                end
                default: begin
                    ref_q <= {`CRS_MV_W{1'b0}};
                    ramp_q <= 1'b0;
                    fast_q <= 1'b0;
                end
            endcase
            // mode inputs count only once running
            if (state_d == ST_RUN) begin
                ccm_q <= wake_n;
                dem_q <= ~wake_n;
                edem_q <= ~wake_n & fde;
            end else begin
                ccm_q <= 1'b1; // RULE3
                dem_q <= 1'b0;
                edem_q <= 1'b0;
            end
            clk_en_n_q <= ~((state_d == ST_SLEW) | (state_d == ST_RUN)); // RULE5 RULE12
            power_good_out_q <= (state_d == ST_RUN); // RULE11 RULE12
        end
    end

    assign reference_level = ref_q;
    assign soft_ramp_en = ramp_q;
    assign slew_fast = fast_q;
    assign continuous_conduction = ccm_q;
    assign diode_emulation = dem_q;
    assign enhanced_diode_emulation = edem_q;
    assign clock_enable_n = clk_en_n_q;
    // open drain: pull low whenever power is not good
    assign power_good_out = 1'b0;
    assign power_good_oe = ~power_good_out_q;

endmodule // crs_sequencer

/* File: testbench/crs_partner.sv */
/* analog output model: raises the near-boot sense a fixed time after the ramp
   starts. assumes soft_ramp_en from the sequencer and the bench clock. */
module crs_partner #(
    parameter int BOOT_DLY = 6
) (
    input wire logic sys_clk,
    input wire logic soft_ramp_en,
    output logic output_voltage_sense
);
    timeunit 1ns;
    timeprecision 1ps;
    int cnt_q = 0; // cycles since the ramp began
    initial output_voltage_sense = 1'b0;
    // sense high once the output has ramped near boot, low with ramp off
    always @(posedge sys_clk) begin
        cnt_q <= soft_ramp_en ? cnt_q + 1 : 0;
        output_voltage_sense <= #1 soft_ramp_en && cnt_q >= BOOT_DLY;
    end
endmodule // crs_partner

/* File: testbench/crs_sva.sv */
/* checker of the start-up sequencer port behaviour.
   assumes it is bound to crs_sequencer; single clock domain. */
`include "crs_defines.vh"
module crs_sva #(
    parameter int POWER_GOOD_OUT_CYC = 50
) (
    input wire sys_clk,
    input wire rstn,
    input wire supply_ok_in,
    input wire regulator_enable_in,
    input wire [6:0] voltage_code,
    input wire output_voltage_sense,
    input wire [`CRS_MV_W-1:0] reference_level,
    input wire soft_ramp_en,
    input wire slew_fast,
    input wire continuous_conduction,
    input wire diode_emulation,
    input wire enhanced_diode_emulation,
    input wire clock_enable_n,
    input wire power_good_oe
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rstn);
    int pg_cnt_q; // cycles since clock enable went low
    always @(posedge sys_clk or negedge rstn) begin
        if (!rstn) pg_cnt_q <= 0;
        else pg_cnt_q <= clock_enable_n ? 0 : pg_cnt_q + 1;
    end
    a_boot_slow: assert property ($rose(soft_ramp_en) |-> reference_level == `CRS_BOOT_LEVEL
        && !slew_fast && clock_enable_n) else $error("ramp start not boot level slow slew");
    a_ccm_startup: assert property (power_good_oe |-> continuous_conduction
        && !diode_emulation && !enhanced_diode_emulation) else $error("ccm not forced");
    a_count_wait: assert property ($fell(clock_enable_n) |-> $past(output_voltage_sense, 13))
        else $error("clock enable before near-boot count");
    a_fast_run: assert property (!clock_enable_n |-> slew_fast && soft_ramp_en)
        else $error("slew not fast with clock enable");
    a_power_good_out_time: assert property ($fell(power_good_oe) |-> pg_cnt_q == POWER_GOOD_OUT_CYC)
        else $error("power good delay wrong");
    a_power_good_out_early: assert property (!clock_enable_n && pg_cnt_q < POWER_GOOD_OUT_CYC |-> power_good_oe)
        else $error("power good too early");
    a_code_track: assert property ((!power_good_oe && $stable(voltage_code))[*6] |->
        reference_level == ((voltage_code <= `CRS_CODE_LAST) ?
        `CRS_CODE_ZERO_LEVEL - `CRS_CODE_STEP * voltage_code : 14'd0))
        else $error("reference not decoded code");
    a_idle_loss: assert property ($fell(regulator_enable_in) || $fell(supply_ok_in) |->
        ##5 clock_enable_n && power_good_oe && !soft_ramp_en) else $error("no idle on loss");
    a_no_start: assert property ((!regulator_enable_in || !supply_ok_in)[*6] |->
        !soft_ramp_en && clock_enable_n) else $error("start without enable");
endmodule // crs_sva
bind crs_sequencer crs_sva #(.POWER_GOOD_OUT_CYC(POWER_GOOD_OUT_CYC)) u_sva (.sys_clk, .rstn, .supply_ok_in,
    .regulator_enable_in, .voltage_code, .output_voltage_sense, .reference_level, .soft_ramp_en,
    .slew_fast, .continuous_conduction, .diode_emulation, .enhanced_diode_emulation,
    .clock_enable_n, .power_good_oe);

/* File: testbench/tb_top.sv */
/* bench of the start-up sequencer: scenario tasks, partner, bound checker.
   assumes shortened start and power good counts set below. */
`include "crs_defines.vh"
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int START_CYC = 10; // shortened start delay
    localparam int POWER_GOOD_OUT_CYC = 50; // shortened power good delay
    localparam int BOOT_DLY = 6; // partner ramp time
    logic sys_clk = 0, rstn = 0, supply_ok_in = 0, regulator_enable_in = 0;
    logic sleep_wake_n = 1, forced_diode_emulation_in = 0;
    logic [6:0] voltage_code = 7'h00;
    wire output_voltage_sense, soft_ramp_en, slew_fast, continuous_conduction, diode_emulation;
    wire enhanced_diode_emulation, clock_enable_n, power_good_out, power_good_oe;
    wire [`CRS_MV_W-1:0] reference_level;
    int fails = 0, samples_checked = 0, cyc = 0, n;
    always #4 sys_clk = ~sys_clk;
    crs_sequencer #(
        .START_CYC(`CRS_CNT_W'(START_CYC)),
        .POWER_GOOD_OUT_CYC(`CRS_CNT_W'(POWER_GOOD_OUT_CYC))
    ) dut (
        .sys_clk(sys_clk),
        .rstn(rstn),
        .supply_ok_in(supply_ok_in),
        .regulator_enable_in(regulator_enable_in),
        .voltage_code(voltage_code),
        .output_voltage_sense(output_voltage_sense),
        .sleep_wake_n(sleep_wake_n),
        .forced_diode_emulation_in(forced_diode_emulation_in),
        .reference_level(reference_level),
        .soft_ramp_en(soft_ramp_en),
        .slew_fast(slew_fast),
        .continuous_conduction(continuous_conduction),
        .diode_emulation(diode_emulation),
        .enhanced_diode_emulation(enhanced_diode_emulation),
        .clock_enable_n(clock_enable_n),
        .power_good_out(power_good_out),
        .power_good_oe(power_good_oe)
    );
    // far-side model of the analog output ramp
    crs_partner #(.BOOT_DLY(BOOT_DLY)) u_partner (
        .sys_clk(sys_clk),
        .soft_ramp_en(soft_ramp_en),
        .output_voltage_sense(output_voltage_sense)
    );
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    // hang guard
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 3000) begin
            fails++;
            report_and_stop();
        end
    end
    task automatic check(string name, logic [31:0] exp, logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            fails++;
            $display("unexpected %s: expected %0h seen %0h", name, exp, got);
        end
    endtask
    task automatic tick(int k = 1);
        repeat (k) @(posedge sys_clk);
        #1;
    endtask
    function automatic logic [13:0] exp_ref(logic [6:0] c);
        return (c <= 7'h6f) ? 14'd15000 - 14'd125 * c : 14'd0;
    endfunction
    // full start-up in deeper sleep with diode emulation requested
    task automatic t_startup(logic [6:0] code);
        voltage_code = code;
        sleep_wake_n = 0;
        forced_diode_emulation_in = 1;
        supply_ok_in = 1;
        regulator_enable_in = 1;
        n = 0;
        while (soft_ramp_en !== 1'b1 && n < 200) begin tick(); n++; end
        check("ramp_delay", START_CYC + 3, n);
        check("boot_level", `CRS_BOOT_LEVEL, reference_level);
        check("slow_slew", 0, slew_fast);
        n = 0;
        while (clock_enable_n !== 1'b0 && n < 200) begin
            check("ccm_forced", 1, continuous_conduction);
            tick();
            n++;
        end
        check("clken_count", 1, n >= BOOT_DLY + 16 && n <= BOOT_DLY + 18);
        check("fast_slew", 1, slew_fast);
        check("target", exp_ref(code), reference_level);
        n = 0;
        while (power_good_oe !== 1'b0 && n < 200) begin tick(); n++; end
        check("power_good_out_delay", POWER_GOOD_OUT_CYC, n);
        check("power_good_out_pin", 0, power_good_out);
        // once running the mode inputs take effect: sleep with forced emulation
        check("mode_edem", 3'b011, {continuous_conduction, diode_emulation,
            enhanced_diode_emulation});
        forced_diode_emulation_in = 0;
        tick(3);
        check("mode_dem", 3'b010, {continuous_conduction, diode_emulation,
            enhanced_diode_emulation});
        sleep_wake_n = 1;
        tick(3);
        check("mode_ccm", 3'b100, {continuous_conduction, diode_emulation,
            enhanced_diode_emulation});
    endtask
    // code changes in run, bit order and table ends
    task automatic t_codes;
        logic [6:0] tbl [6] = '{7'h00, 7'h01, 7'h40, 7'h18, 7'h6f, 7'h70};
        foreach (tbl[i]) begin
            voltage_code = tbl[i];
            tick(4);
            check("code_ref", exp_ref(tbl[i]), reference_level);
        end
    endtask
    // loss of enable in run, loss of supply in ramp
    task automatic t_abort;
        regulator_enable_in = 0;
        tick(5);
        check("idle_en", 3'b110, {clock_enable_n, power_good_oe, soft_ramp_en});
        regulator_enable_in = 1;
        n = 0;
        while (soft_ramp_en !== 1'b1 && n < 200) begin tick(); n++; end
        supply_ok_in = 0;
        tick(5);
        check("idle_sup", 3'b110, {clock_enable_n, power_good_oe, soft_ramp_en});
    endtask
    // enable without supply must not start
    task automatic t_no_start;
        regulator_enable_in = 1;
        tick(40);
        check("no_start", 2'b01, {soft_ramp_en, clock_enable_n});
    endtask
    initial begin
        tick(2);
        rstn = 1;
        tick(2);
        t_no_start();
        t_startup(7'h18);
        t_codes();
        t_abort();
        t_startup(7'h6f);
        report_and_stop();
    end
endmodule // tb_top
